// >>> rtl/pet_edge_calc.sv
`timescale 1ns/1ps
module pet_edge_calc (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [pet_pkg::TIME_W-1:0] loopMod,
  input wire logic [pet_pkg::TIME_W-1:0] balMod,
  pet_edge_if.calc eIf
);

  logic signed [14:0] sum;
  logic [pet_pkg::TIME_W-1:0] edgeTime_q;

  // Base time plus the enabled offsets, kept wide so it cannot wrap.
  always_comb begin
    sum = signed'({3'b000, eIf.baseTime});
    if (eIf.modEn) begin
      if (eIf.modNeg) begin
        sum = sum + signed'({3'b000, loopMod});
      end else begin
        sum = sum - signed'({3'b000, loopMod});
      end
    end
    if (eIf.balEn) begin
      sum = sum + signed'({{3{balMod[11]}}, balMod});
    end
  end

  // The edge is clamped inside the period counter range.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      edgeTime_q <= '0;
    end else if (sum < 0) begin
      edgeTime_q <= '0;
    end else if (sum > signed'({3'b000, pet_pkg::TIME_MAX})) begin
      edgeTime_q <= pet_pkg::TIME_MAX;
    end else begin
      edgeTime_q <= sum[11:0];
    end
  end

  assign eIf.edgeTime = edgeTime_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_noMod;
    @(posedge mclk) disable iff (rst)
    !eIf.modEn && !eIf.balEn |=> eIf.edgeTime == $past(eIf.baseTime);
  endproperty
  a_noMod: assert property (p_noMod) else $error("unmodulated edge moved");

  property p_negMod;
    @(posedge mclk) disable iff (rst)
    eIf.modEn && eIf.modNeg && !eIf.balEn &&
      ({1'b0, eIf.baseTime} + {1'b0, loopMod} <= {1'b0, pet_pkg::TIME_MAX})
    |=> eIf.edgeTime == $past(eIf.baseTime) + $past(loopMod);
  endproperty
  a_negMod: assert property (p_negMod) else $error("negative sign not later");

  property p_posMod;
    @(posedge mclk) disable iff (rst)
    eIf.modEn && !eIf.modNeg && !eIf.balEn && (eIf.baseTime >= loopMod)
    |=> eIf.edgeTime == $past(eIf.baseTime) - $past(loopMod);
  endproperty
  a_posMod: assert property (p_posMod) else $error("positive sign not earlier");

endmodule : pet_edge_calc

// >>> rtl/pet_edge_if.sv
`timescale 1ns/1ps
// Settings of one edge and the edge time worked out from them.
interface pet_edge_if;
  logic [pet_pkg::TIME_W-1:0] baseTime;
  logic modEn;
  logic modNeg;
  logic balEn;
  logic [pet_pkg::TIME_W-1:0] edgeTime;
  modport calc (input baseTime, input modEn, input modNeg, input balEn, output edgeTime);
  modport user (output baseTime, output modEn, output modNeg, output balEn, input edgeTime);
endinterface : pet_edge_if

// >>> rtl/pet_edge_out.sv
`timescale 1ns/1ps
module pet_edge_out (
  input wire logic mclk,
  input wire logic rst,
  input wire logic run,
  input wire logic stepEn,
  input wire logic periodEnd,
  input wire logic [pet_pkg::TIME_W-1:0] cnt,
  input wire logic [pet_pkg::TIME_W-1:0] riseTime,
  input wire logic [pet_pkg::TIME_W-1:0] fallTime,
  output logic drive
);

  logic [pet_pkg::TIME_W-1:0] rise_q;
  logic [pet_pkg::TIME_W-1:0] fall_q;
  logic drive_q;

  // Edge times are taken at the end of a period so none changes mid-period.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      rise_q <= '0;
      fall_q <= '0;
    end else if (!run || periodEnd) begin
      rise_q <= riseTime;
      fall_q <= fallTime;
    end
  end

  // High from the rising time, low from the falling time; fall wins a tie.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      drive_q <= 1'b0;
    end else if (!run) begin
      drive_q <= 1'b0;
    end else if (stepEn && cnt == fall_q) begin
      drive_q <= 1'b0;
    end else if (stepEn && cnt == rise_q) begin
      drive_q <= 1'b1;
    end
  end

  assign drive = drive_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_riseHit;
    run && stepEn && cnt == rise_q && cnt != fall_q;
  endsequence

  property p_riseHigh;
    @(posedge mclk) disable iff (rst)
    s_riseHit |=> drive;
  endproperty
  a_riseHigh: assert property (p_riseHigh) else $error("output missed rise");

  property p_fallLow;
    @(posedge mclk) disable iff (rst)
    run && stepEn && cnt == fall_q |=> !drive;
  endproperty
  a_fallLow: assert property (p_fallLow) else $error("output missed fall");

endmodule : pet_edge_out

// >>> rtl/pet_edge_timing_outputs.sv
// Register access over Wishbone was chosen for this implementation.
`timescale 1ns/1ps
// Function
// - Output D rising time low nibble comes from bits 7:4 of its setting.
// - Output D falling time: timing byte high, setting top nibble low.
// - Rectifier 1 rising time: timing byte high, next register nibble low.
// - Rectifier 1 falling time: timing byte high, next register nibble low.
// - Each count of an edge time moves the edge by 5 ns.
// - Setting bit 3 lets loop modulation move the edge; otherwise it stays.
// - Setting bit 2 high: larger modulation makes the edge later.
// - Setting bit 2 low: larger modulation makes the edge earlier.
// - Balance bit adds balance modulation to rectifier rising edges.
// - Output D rising time high byte comes from its own timing register.
module pet_edge_timing_outputs #(
  parameter int STEP_CYCLES_P = pet_pkg::STEP_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [pet_pkg::ADR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [pet_pkg::TIME_W-1:0] loopModulation,
  input wire logic [pet_pkg::TIME_W-1:0] balanceModulation,
  output logic pwmOutputD,
  output logic rectifierDrive1,
  output logic fluxBalanceRectifierEnable,
  output logic periodStart
);

  // ----------------------------------------------------------------
  // Parameter check
  // ----------------------------------------------------------------
  generate
    if (STEP_CYCLES_P < 1 || STEP_CYCLES_P > 255) begin : g_badStep
      $error("STEP_CYCLES_P must lie in 1..255");
    end
  endgenerate

  localparam int STEP_GAP = STEP_CYCLES_P;
  localparam logic [7:0] STEP_LAST = 8'(STEP_CYCLES_P - 1);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [pet_pkg::REG_W-1:0] edgeReg_q [pet_pkg::EDGE_REGS];
  logic [pet_pkg::REG_W-1:0] ctrl_q;
  logic [pet_pkg::TIME_W-1:0] period_q;
  logic [31:0] datO_q;
  logic ack_q;
  logic [7:0] idx;
  logic [7:0] rel;
  logic inEdge;
  logic req;
  logic wrEn;
  logic [pet_pkg::REG_W-1:0] rdData;
  pet_pkg::pet_state_t state_q;
  logic [7:0] divCnt_q;
  logic stepEn;
  logic [pet_pkg::TIME_W-1:0] cnt_q;
  logic periodEnd;
  logic run;
  logic periodStart_q;
  logic fluxBal_q;
  logic driveD;
  logic driveR1;

  // ----------------------------------------------------------------
  // Wishbone slave
  // ----------------------------------------------------------------
  assign idx = wb_adr_i[9:2];
  assign rel = idx - pet_pkg::IDX_D_RISE_TIM;
  assign inEdge = (idx >= pet_pkg::IDX_D_RISE_TIM) && (idx <= pet_pkg::IDX_R1_FALL_SET);
  assign req = wb_cyc_i && wb_stb_i && !ack_q;
  // A write lands on the edge at which the master sees the acknowledge.
  assign wrEn = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];

  // Read multiplexer; unmapped indices read as zero.
  always_comb begin
    rdData = '0;
    if (inEdge) begin
      rdData = edgeReg_q[rel[2:0]];
    end else begin
      case (idx)
        pet_pkg::IDX_CTRL: rdData = ctrl_q;
        pet_pkg::IDX_PERIOD_HI: rdData = period_q[11:4];
        pet_pkg::IDX_PERIOD_LO: rdData = {4'h0, period_q[3:0]};
        pet_pkg::IDX_STATUS: rdData = {5'h00, run, driveR1, driveD};
        default: rdData = '0;
      endcase
    end
  end

  // One acknowledge per request, one cycle after it is seen.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ack_q <= 1'b0;
      datO_q <= 32'h0000_0000;
    end else begin
      ack_q <= req;
      if (req) begin
        datO_q <= {24'h00_0000, rdData};
      end
    end
  end

  // Edge timing and setting bytes; reserved bits are stored but unused.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < pet_pkg::EDGE_REGS; i++) begin
        edgeReg_q[i] <= pet_pkg::EDGE_REG_RST;
      end
    end else if (wrEn && inEdge) begin
      edgeReg_q[rel[2:0]] <= wb_dat_i[7:0];
    end
  end

  // Run control and period length.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrl_q <= pet_pkg::CTRL_RST;
      period_q <= pet_pkg::PERIOD_RST;
    end else if (wrEn) begin
      case (idx)
        pet_pkg::IDX_CTRL: ctrl_q <= wb_dat_i[7:0];
        pet_pkg::IDX_PERIOD_HI: period_q[11:4] <= wb_dat_i[7:0];
        pet_pkg::IDX_PERIOD_LO: period_q[3:0] <= wb_dat_i[3:0];
        default: ctrl_q <= ctrl_q;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = datO_q;

  // ----------------------------------------------------------------
  // Step divider and period counter
  // ----------------------------------------------------------------
  assign stepEn = (divCnt_q == STEP_LAST);
  assign periodEnd = stepEn && (cnt_q == period_q);
  assign run = (state_q == pet_pkg::PET_RUN);

  // One step enable per 5 ns of edge resolution.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      divCnt_q <= '0;
    end else if (stepEn) begin
      divCnt_q <= '0;
    end else begin
      divCnt_q <= divCnt_q + 8'h01;
    end
  end

  // Run state follows the control bit, starting only on a step.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= pet_pkg::PET_IDLE;
    end else begin
      case (state_q)
        pet_pkg::PET_IDLE: begin
          if (ctrl_q[pet_pkg::RUN_BIT] && stepEn) begin
            state_q <= pet_pkg::PET_RUN;
          end
        end
        pet_pkg::PET_RUN: begin
          if (!ctrl_q[pet_pkg::RUN_BIT]) begin
            state_q <= pet_pkg::PET_IDLE;
          end
        end
        default: state_q <= pet_pkg::PET_IDLE;
      endcase
    end
  end

  // Counts edge-time steps from the start of each period.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_q <= '0;
    end else if (!run) begin
      cnt_q <= '0;
    end else if (periodEnd) begin
      cnt_q <= '0;
    end else if (stepEn) begin
      cnt_q <= cnt_q + 12'h001;
    end
  end

  // Period start pulse and balance flag passed on to rectifier drive 2.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      periodStart_q <= 1'b0;
      fluxBal_q <= 1'b0;
    end else begin
      periodStart_q <= run && stepEn && (cnt_q == '0);
      fluxBal_q <= edgeReg_q[5][pet_pkg::BAL_BIT];
    end
  end

  assign periodStart = periodStart_q;
  assign fluxBalanceRectifierEnable = fluxBal_q;

  // ----------------------------------------------------------------
  // Edge calculators
  // ----------------------------------------------------------------
  pet_edge_if edgeIf [pet_pkg::EDGE_N] ();

  generate
    for (genvar e = 0; e < pet_pkg::EDGE_N; e++) begin : g_edge
      // Timing byte gives the high eight bits, setting nibble the low four.
      assign edgeIf[e].baseTime = {edgeReg_q[2*e],
                                   edgeReg_q[2*e+1][pet_pkg::NIB_HI:pet_pkg::NIB_LO]};
      assign edgeIf[e].modEn = edgeReg_q[2*e+1][pet_pkg::MOD_EN_BIT];
      assign edgeIf[e].modNeg = edgeReg_q[2*e+1][pet_pkg::MOD_NEG_BIT];
      // Only the rectifier rising edge takes balance modulation here.
      if (e == pet_pkg::E_R1_RISE) begin : g_bal
        assign edgeIf[e].balEn = edgeReg_q[2*e+1][pet_pkg::BAL_BIT];
      end else begin : g_noBal
        assign edgeIf[e].balEn = 1'b0;
      end
      pet_edge_calc u_calc (
        .mclk(mclk),
        .rst(rst),
        .loopMod(loopModulation),
        .balMod(balanceModulation),
        .eIf(edgeIf[e])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Output drivers
  // ----------------------------------------------------------------
  pet_edge_out u_pwm_output_d (
    .mclk(mclk),
    .rst(rst),
    .run(run),
    .stepEn(stepEn),
    .periodEnd(periodEnd),
    .cnt(cnt_q),
    .riseTime(edgeIf[pet_pkg::E_D_RISE].edgeTime),
    .fallTime(edgeIf[pet_pkg::E_D_FALL].edgeTime),
    .drive(driveD)
  );

  pet_edge_out u_outR1 (
    .mclk(mclk),
    .rst(rst),
    .run(run),
    .stepEn(stepEn),
    .periodEnd(periodEnd),
    .cnt(cnt_q),
    .riseTime(edgeIf[pet_pkg::E_R1_RISE].edgeTime),
    .fallTime(edgeIf[pet_pkg::E_R1_FALL].edgeTime),
    .drive(driveR1)
  );

  assign pwmOutputD = driveD;
  assign rectifierDrive1 = driveR1;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  sequence s_write(logic [7:0] wIdx);
    wrEn && idx == wIdx;
  endsequence

  property p_dRiseLow;
    @(posedge mclk) disable iff (rst)
    s_write(pet_pkg::IDX_D_RISE_SET) |=> edgeIf[0].baseTime[3:0] == $past(wb_dat_i[7:4]);
  endproperty
  a_dRiseLow: assert property (p_dRiseLow) else $error("D rise nibble wrong");

  property p_dRiseHigh;
    @(posedge mclk) disable iff (rst)
    s_write(pet_pkg::IDX_D_RISE_TIM) |=> edgeIf[0].baseTime[11:4] == $past(wb_dat_i[7:0]);
  endproperty
  a_dRiseHigh: assert property (p_dRiseHigh) else $error("D rise byte wrong");

  property p_dFallLow;
    @(posedge mclk) disable iff (rst)
    s_write(pet_pkg::IDX_D_FALL_SET) |=> edgeIf[1].baseTime[3:0] == $past(wb_dat_i[7:4]);
  endproperty
  a_dFallLow: assert property (p_dFallLow) else $error("D fall nibble wrong");

  property p_r1RiseHigh;
    @(posedge mclk) disable iff (rst)
    s_write(pet_pkg::IDX_R1_RISE_TIM) |=> edgeIf[2].baseTime[11:4] == $past(wb_dat_i[7:0]);
  endproperty
  a_r1RiseHigh: assert property (p_r1RiseHigh) else $error("R1 rise byte wrong");

  property p_r1FallLow;
    @(posedge mclk) disable iff (rst)
    s_write(pet_pkg::IDX_R1_FALL_SET) |=> edgeIf[3].baseTime[3:0] == $past(wb_dat_i[7:4]);
  endproperty
  a_r1FallLow: assert property (p_r1FallLow) else $error("R1 fall nibble wrong");

  property p_stepRate;
    @(posedge mclk) disable iff (rst)
    stepEn |-> ##STEP_GAP stepEn;
  endproperty
  a_stepRate: assert property (p_stepRate) else $error("step rate wrong");

  property p_countStep;
    @(posedge mclk) disable iff (rst)
    run && stepEn && !periodEnd && ctrl_q[pet_pkg::RUN_BIT] |=> cnt_q == $past(cnt_q) + 12'h001;
  endproperty
  a_countStep: assert property (p_countStep) else $error("counter skipped");

  property p_balOnlyR1;
    @(posedge mclk) disable iff (rst)
    s_write(pet_pkg::IDX_R1_RISE_SET) |=> ##1 fluxBalanceRectifierEnable == $past(wb_dat_i[1], 2)
      && !edgeIf[0].balEn && !edgeIf[3].balEn;
  endproperty
  a_balOnlyR1: assert property (p_balOnlyR1) else $error("balance enable wrong");

endmodule : pet_edge_timing_outputs

// >>> rtl/pet_pkg.sv
package pet_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  // One edge-time count is one step of this many nanoseconds.
  localparam int STEP_NS = 5;
  localparam int CLK_NS = 5;
  localparam int STEP_CYCLES = (STEP_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // Widths and field positions
  // ----------------------------------------------------------------
  localparam int TIME_W = 12;
  localparam int REG_W = 8;
  localparam int ADR_W = 10;
  localparam int NIB_HI = 7;
  localparam int NIB_LO = 4;
  localparam int MOD_EN_BIT = 3;
  localparam int MOD_NEG_BIT = 2;
  localparam int BAL_BIT = 1;
  localparam int RUN_BIT = 0;
  localparam logic [TIME_W-1:0] TIME_MAX = 12'hFFF;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_CTRL = 8'h00;
  localparam logic [7:0] IDX_PERIOD_HI = 8'h01;
  localparam logic [7:0] IDX_PERIOD_LO = 8'h02;
  localparam logic [7:0] IDX_STATUS = 8'h03;
  localparam logic [7:0] IDX_D_RISE_TIM = 8'h4D;
  localparam logic [7:0] IDX_D_RISE_SET = 8'h4E;
  localparam logic [7:0] IDX_D_FALL_TIM = 8'h4F;
  localparam logic [7:0] IDX_D_FALL_SET = 8'h50;
  localparam logic [7:0] IDX_R1_RISE_TIM = 8'h51;
  localparam logic [7:0] IDX_R1_RISE_SET = 8'h52;
  localparam logic [7:0] IDX_R1_FALL_TIM = 8'h53;
  localparam logic [7:0] IDX_R1_FALL_SET = 8'h54;
  localparam int EDGE_REGS = 8;

  // Edge slots handled by the edge calculators.
  localparam int E_D_RISE = 0;
  localparam int E_D_FALL = 1;
  localparam int E_R1_RISE = 2;
  localparam int E_R1_FALL = 3;
  localparam int EDGE_N = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [REG_W-1:0] EDGE_REG_RST = 8'h00;
  localparam logic [REG_W-1:0] CTRL_RST = 8'h00;
  localparam logic [TIME_W-1:0] PERIOD_RST = 12'hFFF;

  typedef enum logic [1:0] {
    PET_IDLE = 2'b01,
    PET_RUN = 2'b10
  } pet_state_t;

endpackage : pet_pkg

// >>> tb/pet_gate_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Gate driver model of the power stage
// ----------------------------------------------------------------
module pet_gate_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic periodStart,
  input wire logic pwmOutputD,
  input wire logic rectifierDrive1,
  output logic [15:0] riseD,
  output logic [15:0] fallD,
  output logic [15:0] riseR,
  output logic [15:0] fallR,
  output logic [15:0] periodLen
);
  logic [15:0] cycleQ;
  logic [15:0] startQ;
  logic prevDQ;
  logic prevRQ;

  // Records each switch edge as a cycle offset from the start of its period.
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cycleQ <= 16'h0000;
      startQ <= 16'h0000;
      prevDQ <= 1'b0;
      prevRQ <= 1'b0;
      riseD <= 16'h0000;
      fallD <= 16'h0000;
      riseR <= 16'h0000;
      fallR <= 16'h0000;
      periodLen <= 16'h0000;
    end else begin
      cycleQ <= cycleQ + 16'h0001;
      prevDQ <= pwmOutputD;
      prevRQ <= rectifierDrive1;
      if (periodStart === 1'b1) begin
        startQ <= cycleQ;
        periodLen <= cycleQ - startQ;
      end
      // One cycle at 200 MHz is one 5 ns count of an edge time.
      if (pwmOutputD === 1'b1 && prevDQ === 1'b0) riseD <= cycleQ - startQ;
      if (pwmOutputD === 1'b0 && prevDQ === 1'b1) fallD <= cycleQ - startQ;
      if (rectifierDrive1 === 1'b1 && prevRQ === 1'b0) riseR <= cycleQ - startQ;
      if (rectifierDrive1 === 1'b0 && prevRQ === 1'b1) fallR <= cycleQ - startQ;
    end
  end
endmodule : pet_gate_model

// >>> tb/tb_top.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------
// Testbench of the edge timing outputs
// ----------------------------------------------------------------
module tb_top;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [pet_pkg::ADR_W-1:0] adr = '0;
  logic [3:0] sel = 4'h0;
  logic [31:0] datI = 32'h0000_0000;
  logic [31:0] datO;
  logic ack;
  logic [pet_pkg::TIME_W-1:0] loopMod = 12'h000;
  logic [pet_pkg::TIME_W-1:0] balMod = 12'h000;
  logic pwm_output_d, outR1, balEnOut, pStart;
  logic [15:0] riseD, fallD, riseR, fallR, periodLen;
  logic [7:0] rd;
  int failures = 0;
  int checks = 0;
  int cycleCount = 0;

  // The clock toggles every half period of 2.5 ns.
  always #2.5 mclk = ~mclk;

  pet_edge_timing_outputs i_pet_edge_timing_outputs (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datI),
    .wb_dat_o(datO), .wb_ack_o(ack), .loopModulation(loopMod), .balanceModulation(balMod),
    .pwmOutputD(pwm_output_d), .rectifierDrive1(outR1), .fluxBalanceRectifierEnable(balEnOut),
    .periodStart(pStart));

  pet_gate_model i_pet_gate_model (.mclk(mclk), .rst(rst), .periodStart(pStart),
    .pwmOutputD(pwm_output_d), .rectifierDrive1(outR1), .riseD(riseD), .fallD(fallD), .riseR(riseR),
    .fallR(fallR), .periodLen(periodLen));

  // Prints the counts and the verdict, then ends the run.
  task automatic final_report();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  // Compares one value seen with the value expected.
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  // One classic Wishbone cycle, held until ack is sampled high.
  task automatic wbXfer(input logic w, input logic [7:0] idx, input logic [7:0] wd,
                        input logic [3:0] s, output logic [7:0] r);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    datI <= {24'h00_0000, wd};
    sel <= s;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) check("wb ack", 16'h0000, 16'h0001);
    r = datO[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge mclk);
  endtask : wbXfer

  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] r;
    wbXfer(1'b1, idx, wd, 4'h1, r);
  endtask : wr

  task automatic rdChk(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    wbXfer(1'b0, idx, 8'h00, 4'h1, r);
    check("register read", {8'h00, r}, {8'h00, exp});
  endtask : rdChk

  // Writes all eight edge registers from 0x4D upward.
  task automatic cfg(input logic [63:0] v);
    for (int i = 0; i < 8; i++) begin
      wr(8'h4D + 8'(i), v[63-8*i -: 8]);
    end
  endtask : cfg

  // Lets edge times latch, then compares the four edge offsets.
  task automatic measure(input logic [15:0] eRd, input logic [15:0] eFd,
                         input logic [15:0] eRr, input logic [15:0] eFr);
    for (int p = 0; p < 3; p++) begin
      int n;
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (pStart !== 1'b1 && n < 200);
      if (n >= 200) check("period start", 16'h0000, 16'h0001);
    end
    repeat (70) @(posedge mclk);
    check("period length", periodLen, 16'h0041);
    check("D rise", riseD, eRd);
    check("D fall", fallD, eFd);
    check("R1 rise", riseR, eRr);
    check("R1 fall", fallR, eFr);
  endtask : measure

  // Cuts a hang short.
  always @(posedge mclk) begin
    cycleCount <= cycleCount + 1;
    if (cycleCount == 8000) begin
      failures++;
      final_report();
    end
  end

  // Main sequence; setting bits 1:0 are written as zero except the balance bit.
  initial begin
    logic [7:0] r;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rdChk(8'h4D, 8'h00);
    rdChk(8'h54, 8'h00);
    rdChk(8'h01, 8'hFF);
    rdChk(8'h02, 8'h0F);
    rdChk(8'h03, 8'h00);
    wr(8'h01, 8'h04);
    wr(8'h02, 8'h00);
    cfg(64'h0150_0340_0200_03B0);
    wbXfer(1'b1, 8'h4D, 8'hFF, 4'h0, r);
    rdChk(8'h4D, 8'h01);
    rdChk(8'h4E, 8'h50);
    rdChk(8'h54, 8'hB0);
    wr(8'h60, 8'h55);
    rdChk(8'h60, 8'h00);
    wr(8'h00, 8'h01);
    rdChk(8'h00, 8'h01);
    loopMod <= 12'h003;
    balMod <= 12'h002;
    measure(16'h0015, 16'h0034, 16'h0020, 16'h003B);
    check("balance enable", {15'h0000, balEnOut}, 16'h0000);
    cfg(64'h015C_0348_0202_03B4);
    measure(16'h0018, 16'h0031, 16'h0022, 16'h003B);
    check("balance enable", {15'h0000, balEnOut}, 16'h0001);
    loopMod <= 12'h005;
    balMod <= 12'hFFE;
    measure(16'h001A, 16'h002F, 16'h001E, 16'h003B);
    final_report();
  end
endmodule : tb_top
